/* File: core/failover_ctrl.sv */
// Role negotiation and handover decision for one of two redundant managers.
// Assumes the peer is the same logic, cross-connected on health and
// negotiation lines, and that peer score data is stable while valid is high.
//
// Summary of operation
// (R1) Withdrawal forces handover to operational standby
// (R2) Own health deasserted forces handover
// (R3) Reboot request hands over before restart
// (R4) Reset button held over five seconds forces
// (R5) Lower sync version than standby forces
// (R6) No management bus link blocks handover
// (R7) Incomplete data sync blocks handover
// (R8) Score is sum of asserted condition weights
// (R9) Degradation: hand over if standby strictly lower
// (R10) Every refused evaluation writes a log entry
// (R11) First trap target ping failure degrades
// (R12) Absent or unhealthy paired switch degrades
// (R13) Own sensor nonrecoverable crossing degrades
// (R14) Both critical: compare majors, then minors
// (R15) Ejector or manual: standby equal or better
// (R16) Manual only on active; takeover immediate
// (R17) Refused manual: reason to requester, logged
// (R18) Role exchange at pins without delay
// (R19) Two managers settle roles automatically
// (R20) Never both managers active at once
// (R21) Standby may take over by negotiation low
// (R22) Handover by deasserting own health output
// (R23) Inputs synchronised; role outputs registered, safe
// (R24) Blocking wins over forcing and score
`timescale 1ns/100ps
module failover_ctrl
  import failover_pkg::*;
#(
  parameter int unsigned PRESS_CYCLES = PRESS_CYCLES_DEF,
  parameter logic [SCORE_W-1:0] W_TRAP = WEIGHT_DEFAULT,
  parameter logic [SCORE_W-1:0] W_SWITCH = WEIGHT_DEFAULT,
  parameter logic [SCORE_W-1:0] W_SENSOR = WEIGHT_DEFAULT
) (
  // Clocking
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  // Own board conditions
  input wire local_status_t own_in,
  // Peer board lines and score answer
  input wire peer_status_t peer_in,
  // Cross-connected outputs toward the peer
  output logic health_out_n,
  output logic role_negotiate_out,
  output logic score_req,
  output logic [SCORE_W-1:0] own_score,
  // Role and reports to local software
  output logic role_active,
  output logic restart_go,
  output logic manual_done,
  output logic manual_refused,
  output reason_t refuse_reason,
  output log_entry_t log_out
);

  local_status_t own;
  peer_status_t peer;

  sync_2ff #(.W($bits(local_status_t))) u_sync_own ( // R23
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .d(own_in),
    .q(own)
  );

  sync_2ff #(.W($bits(peer_status_t))) u_sync_peer ( // R23
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .d(peer_in),
    .q(peer)
  );

  logic press_long;

  hold_timer #(.CYCLES(PRESS_CYCLES)) u_press ( // R4
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .level(own.reset_btn),
    .expired(press_long)
  );

  function automatic logic [SCORE_W-1:0] weigh(input logic cond,
                                               input logic [SCORE_W-1:0] w);
    return cond ? w : '0;
  endfunction

  // Critical counts decide only when both sides report critical events
  function automatic logic peer_wins(input logic allow_eq,
                                     input peer_status_t p,
                                     input local_status_t o,
                                     input logic [SCORE_W-1:0] os);
    if (p.critical && o.sensor_crit) begin
      if (p.major_cnt != o.major_cnt) begin
        return p.major_cnt < o.major_cnt; // R14
      end
      return allow_eq ? (p.minor_cnt <= o.minor_cnt) : (p.minor_cnt < o.minor_cnt); // R14
    end
    return allow_eq ? (p.score <= os) : (p.score < os); // R9 R15
  endfunction

  // Decision terms
  logic degrade;
  logic [SCORE_W-1:0] score_now;
  logic standby_ok;
  logic force_lvl;
  reason_t block_rsn;

  always_comb begin
    degrade = own.trap_fail || own.sensor_crit; // R11 R13
    degrade = degrade || !own.switch_present || own.switch_healthy_n; // R12
    score_now = weigh(own.trap_fail, W_TRAP) + weigh(own.sensor_crit, W_SENSOR); // R8
    score_now = score_now + weigh(!own.switch_present || own.switch_healthy_n, W_SWITCH); // R8
    standby_ok = !peer.present_n && !peer.healthy_n;
    force_lvl = !own.seated || own.healthy_n; // R1 R2
    force_lvl = force_lvl || press_long || (own.version < peer.version); // R4 R5
    block_rsn = RSN_NONE;
    if (!own.link_ok) begin
      block_rsn = RSN_NO_LINK; // R6
    end else if (!own.sync_done) begin
      block_rsn = RSN_NOT_SYNCED; // R7
    end
  end

  // Role state and outputs
  role_state_t state_r, state_nxt;
  logic health_r, health_nxt;
  logic neg_r, neg_nxt;
  logic active_r, active_nxt;
  logic req_r, req_nxt;
  logic [SCORE_W-1:0] score_r, score_nxt;
  logic restart_r, restart_nxt;
  logic mdone_r, mdone_nxt;
  logic mref_r, mref_nxt;
  reason_t rsn_r, rsn_nxt;
  log_entry_t log_r, log_nxt;
  logic reboot_r, reboot_nxt;
  logic eval_eq_r, eval_eq_nxt;
  logic eval_man_r, eval_man_nxt;
  logic [TMO_W-1:0] tmo_r, tmo_nxt;
  logic force_prev_r, deg_prev_r, eject_prev_r;

  logic force_rise;
  logic deg_rise;
  logic eject_rise;
  reason_t fail_rsn;
  logic man_ctx;
  logic go_over;

  always_comb begin
    force_rise = force_lvl && !force_prev_r;
    deg_rise = degrade && !deg_prev_r;
    eject_rise = own.eject_open && !eject_prev_r;
    state_nxt = state_r;
    health_nxt = health_r;
    neg_nxt = neg_r;
    active_nxt = active_r;
    req_nxt = 1'b0;
    score_nxt = score_now;
    restart_nxt = 1'b0;
    mdone_nxt = 1'b0;
    mref_nxt = 1'b0;
    rsn_nxt = rsn_r;
    log_nxt = '{valid: 1'b0, reason: RSN_NONE};
    reboot_nxt = reboot_r || own.reboot_req;
    eval_eq_nxt = eval_eq_r;
    eval_man_nxt = eval_man_r;
    tmo_nxt = tmo_r;
    fail_rsn = RSN_NONE;
    man_ctx = own.manual_req;
    go_over = 1'b0;
    unique case (state_r)
      ST_NEGOTIATE: begin
        health_nxt = own.healthy_n;
        neg_nxt = 1'b1;
        active_nxt = 1'b0;
        if (own.seated && !own.healthy_n) begin
          if (!peer.negotiate && !peer.present_n) begin
            state_nxt = ST_STANDBY; // R19
          end else if (peer.present_n || own.slot_primary) begin
            state_nxt = ST_TAKEOVER; // R19
            neg_nxt = 1'b0;
          end
        end
      end
      ST_STANDBY: begin
        health_nxt = own.healthy_n;
        neg_nxt = 1'b1;
        active_nxt = 1'b0;
        if (own.seated && !own.healthy_n &&
            (peer.present_n || peer.healthy_n || peer.negotiate)) begin
          state_nxt = ST_TAKEOVER;
          neg_nxt = 1'b0;
        end
      end
      ST_TAKEOVER: begin
        health_nxt = own.healthy_n;
        if (own.healthy_n || !own.seated) begin
          state_nxt = ST_STANDBY;
          neg_nxt = 1'b1;
        end else if (peer.negotiate || peer.present_n) begin
          // Peer has yielded, so only one side can be active
          state_nxt = ST_ACTIVE; // R20
          active_nxt = 1'b1;
        end
      end
      ST_ACTIVE: begin
        health_nxt = own.healthy_n;
        neg_nxt = 1'b0;
        active_nxt = 1'b1;
        if (!peer.negotiate && !peer.present_n) begin
          go_over = 1'b1; // R21
        end else if (force_lvl || reboot_r) begin
          if (block_rsn != RSN_NONE) begin
            fail_rsn = (force_rise || reboot_r) ? block_rsn : RSN_NONE; // R24
          end else if (standby_ok) begin
            go_over = 1'b1; // R1 R2 R3 R4 R5
          end else if (force_rise || reboot_r) begin
            fail_rsn = RSN_NO_STANDBY; // R10
          end
        end else if (deg_rise || eject_rise || own.manual_req) begin
          if (block_rsn != RSN_NONE) begin
            fail_rsn = block_rsn; // R6 R7 R24
          end else begin
            state_nxt = ST_SCORE_WAIT; // R9
            req_nxt = 1'b1;
            eval_eq_nxt = !deg_rise;
            eval_man_nxt = own.manual_req && !deg_rise && !eject_rise;
            tmo_nxt = '0;
          end
        end
      end
      ST_SCORE_WAIT: begin
        health_nxt = own.healthy_n;
        req_nxt = 1'b1;
        man_ctx = eval_man_r;
        tmo_nxt = tmo_r + 1'b1;
        if (!peer.negotiate && !peer.present_n) begin
          go_over = 1'b1;
        end else if (block_rsn != RSN_NONE) begin
          fail_rsn = block_rsn; // R24
        end else if (peer.score_valid) begin
          if (peer_wins(eval_eq_r, peer, own, score_now)) begin
            go_over = 1'b1; // R9 R15
          end else begin
            fail_rsn = RSN_NOT_HEALTHIER; // R10
          end
        end else if (tmo_r == TMO_W'(SCORE_TMO_CYCLES - 1)) begin
          fail_rsn = RSN_NO_ANSWER;
        end
        if (go_over || fail_rsn != RSN_NONE) begin
          req_nxt = 1'b0;
          state_nxt = ST_ACTIVE;
        end
      end
      ST_YIELD: begin
        health_nxt = 1'b1;
        neg_nxt = 1'b1;
        active_nxt = 1'b0;
        if (!peer.negotiate || peer.present_n) begin
          state_nxt = ST_STANDBY;
        end
      end
      default: begin
        state_nxt = ST_NEGOTIATE;
      end
    endcase

    // Handover drops the role at the pins in the same edge
    if (go_over) begin
      state_nxt = ST_YIELD;
      health_nxt = 1'b1; // R22 R18
      neg_nxt = 1'b1;
      active_nxt = 1'b0; // R18
      req_nxt = 1'b0;
      if (man_ctx) begin
        mdone_nxt = 1'b1; // R16
      end
    end

    // Manual requests only count on the active manager
    if (own.manual_req && state_r != ST_ACTIVE && state_r != ST_SCORE_WAIT) begin
      fail_rsn = RSN_NOT_ACTIVE; // R16
    end

    if (fail_rsn != RSN_NONE) begin
      log_nxt = '{valid: 1'b1, reason: fail_rsn}; // R10
      if (man_ctx || fail_rsn == RSN_NOT_ACTIVE) begin
        mref_nxt = 1'b1; // R17
        rsn_nxt = fail_rsn; // R17
      end
    end

    // A pending reboot restarts after handing over, or once refused
    if (reboot_r && (state_r == ST_YIELD || state_r == ST_STANDBY ||
                     state_r == ST_NEGOTIATE || fail_rsn != RSN_NONE)) begin
      restart_nxt = 1'b1; // R3
      reboot_nxt = own.reboot_req;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_NEGOTIATE;
      health_r <= HEALTH_OUT_RST; // R23
      neg_r <= NEGOTIATE_OUT_RST; // R23
      active_r <= 1'b0; // R23
      req_r <= 1'b0;
      score_r <= '0;
      restart_r <= 1'b0;
      mdone_r <= 1'b0;
      mref_r <= 1'b0;
      rsn_r <= RSN_NONE;
      log_r <= '{valid: 1'b0, reason: RSN_NONE};
      reboot_r <= 1'b0;
      eval_eq_r <= 1'b0;
      eval_man_r <= 1'b0;
      tmo_r <= '0;
      force_prev_r <= 1'b0;
      deg_prev_r <= 1'b0;
      eject_prev_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      health_r <= health_nxt;
      neg_r <= neg_nxt;
      active_r <= active_nxt;
      req_r <= req_nxt;
      score_r <= score_nxt;
      restart_r <= restart_nxt;
      mdone_r <= mdone_nxt;
      mref_r <= mref_nxt;
      rsn_r <= rsn_nxt;
      log_r <= log_nxt;
      reboot_r <= reboot_nxt;
      eval_eq_r <= eval_eq_nxt;
      eval_man_r <= eval_man_nxt;
      tmo_r <= tmo_nxt;
      force_prev_r <= force_lvl;
      deg_prev_r <= degrade;
      eject_prev_r <= own.eject_open;
    end
  end

  assign health_out_n = health_r;
  assign role_negotiate_out = neg_r;
  assign role_active = active_r;
  assign score_req = req_r;
  assign own_score = score_r;
  assign restart_go = restart_r;
  assign manual_done = mdone_r;
  assign manual_refused = mref_r;
  assign refuse_reason = rsn_r;
  assign log_out = log_r;

endmodule

/* File: core/failover_pkg.sv */
// Shared constants, types and carriers for the manager handover logic.
// Assumes a single 40 MHz system clock; everything here is compile-time only.
package failover_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned PRESS_MS = 5000;
  localparam int unsigned PRESS_CYCLES_DEF = PRESS_MS * (CLK_HZ / 1000);
  localparam int unsigned SCORE_TMO_CYCLES = 1024;
  localparam int TMO_W = 11;

  // Field widths
  localparam int SCORE_W = 4;
  localparam int EVCNT_W = 8;
  localparam int VER_W = 8;

  // Default weight of every degradation condition
  localparam logic [SCORE_W-1:0] WEIGHT_DEFAULT = 4'h1;

  // Safe values of the role outputs under reset
  localparam logic HEALTH_OUT_RST = 1'b1;
  localparam logic NEGOTIATE_OUT_RST = 1'b1;

  typedef enum logic [2:0] {
    ST_NEGOTIATE  = 3'b000,
    ST_STANDBY    = 3'b001,
    ST_TAKEOVER   = 3'b010,
    ST_ACTIVE     = 3'b011,
    ST_SCORE_WAIT = 3'b100,
    ST_YIELD      = 3'b101
  } role_state_t;

  typedef enum logic [2:0] {
    RSN_NONE          = 3'h0,
    RSN_NO_LINK       = 3'h1,
    RSN_NOT_SYNCED    = 3'h2,
    RSN_NO_STANDBY    = 3'h3,
    RSN_NOT_HEALTHIER = 3'h4,
    RSN_NO_ANSWER     = 3'h5,
    RSN_NOT_ACTIVE    = 3'h6
  } reason_t;

  // Conditions of this board, as seen at its own pins
  typedef struct packed {
    logic slot_primary;
    logic seated;
    logic healthy_n;
    logic reboot_req;
    logic reset_btn;
    logic eject_open;
    logic manual_req;
    logic link_ok;
    logic sync_done;
    logic trap_fail;
    logic switch_present;
    logic switch_healthy_n;
    logic sensor_crit;
    logic [EVCNT_W-1:0] major_cnt;
    logic [EVCNT_W-1:0] minor_cnt;
    logic [VER_W-1:0] version;
  } local_status_t;

  // What the peer board reports on the cross-connected lines and bus
  typedef struct packed {
    logic present_n;
    logic healthy_n;
    logic negotiate;
    logic score_valid;
    logic critical;
    logic [SCORE_W-1:0] score;
    logic [EVCNT_W-1:0] major_cnt;
    logic [EVCNT_W-1:0] minor_cnt;
    logic [VER_W-1:0] version;
  } peer_status_t;

  typedef struct packed {
    logic valid;
    reason_t reason;
  } log_entry_t;

endpackage

/* File: core/sync_2ff.sv */
// Two-flop synchroniser for a bundle of levels.
// Assumes each bit is independent; multi-bit data must be stable when used.
`timescale 1ns/100ps
module sync_2ff #(
  parameter int W = 1
) (
  // Clocking
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else if (ce) begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule

/* File: core/hold_timer.sv */
// Measures a continuous press; flags once it has lasted beyond CYCLES.
// Assumes the level input is already synchronised.
`timescale 1ns/100ps
module hold_timer #(
  parameter int unsigned CYCLES = 16,
  parameter int CW = $clog2(CYCLES + 1)
) (
  // Clocking
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  // Press level and result
  input wire logic level,
  output logic expired
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // Saturates so a held button keeps the flag without wrapping
  always_comb begin
    cnt_nxt = cnt_r;
    if (!level) begin
      cnt_nxt = '0;
    end else if (cnt_r != CW'(CYCLES)) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign expired = level && (cnt_r == CW'(CYCLES));
endmodule

/* File: sim/failover_properties.sv */
// Concurrent checks on the ports of the handover controller.
// Assumes one clock domain; bound onto every failover_ctrl instance.
`timescale 1ns/100ps
module failover_properties
  import failover_pkg::*;
(
  // Clocking
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  // Watched inputs
  input wire local_status_t own_in,
  input wire peer_status_t peer_in,
  // Watched outputs
  input wire logic health_out_n,
  input wire logic role_negotiate_out,
  input wire logic score_req,
  input wire logic [SCORE_W-1:0] own_score,
  input wire logic role_active,
  input wire logic restart_go,
  input wire logic manual_done,
  input wire logic manual_refused,
  input wire reason_t refuse_reason,
  input wire log_entry_t log_out
);
  // Answer timeout plus pipeline slack
  localparam int ASK_MAX = 1030;
  logic gate_ok;
  logic [10:0] ask_cnt_r;
  assign gate_ok = own_in.link_ok & own_in.sync_done;

  // Too long for a delay range, so the wait is counted here
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ask_cnt_r <= 11'h000;
    end else if (ce) begin
      ask_cnt_r <= score_req ? ask_cnt_r + 11'h001 : 11'h000;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_ask;
    $rose(score_req);
  endsequence
  reset_safe_a: assert property (disable iff (1'b0)
    !reset_n |-> health_out_n && role_negotiate_out && !role_active)
    else $error("role outputs not safe in reset");
  active_claims_a: assert property (role_active |-> !role_negotiate_out)
    else $error("active without claim");
  handover_pins_a: assert property ($fell(role_active) |->
    health_out_n && role_negotiate_out) else $error("handover pins wrong");
  // Sync delay is two or three edges, so a window of samples is allowed
  handover_gated_a: assert property ($fell(role_active) |->
    $past(gate_ok, 2) || $past(gate_ok, 3) || $past(gate_ok, 4) ||
    !$past(peer_in.negotiate, 2) || !$past(peer_in.negotiate, 3))
    else $error("handover while blocked");
  done_drops_a: assert property (manual_done |-> !role_active && role_negotiate_out)
    else $error("manual done without yield");
  refuse_logs_a: assert property (manual_refused |->
    log_out.valid && log_out.reason == refuse_reason) else $error("refusal not logged");
  log_reason_a: assert property (log_out.valid |-> log_out.reason != RSN_NONE)
    else $error("log entry without reason");
  answer_bound_a: assert property (score_req |-> ask_cnt_r < ASK_MAX)
    else $error("score wait not bounded");
  ask_active_a: assert property (s_ask |-> role_active)
    else $error("score asked while not active");
endmodule

bind failover_ctrl failover_properties i_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .own_in(own_in), .peer_in(peer_in),
  .health_out_n(health_out_n), .role_negotiate_out(role_negotiate_out),
  .score_req(score_req), .own_score(own_score), .role_active(role_active),
  .restart_go(restart_go), .manual_done(manual_done), .manual_refused(manual_refused),
  .refuse_reason(refuse_reason), .log_out(log_out)
);

/* File: sim/peer_model.sv */
// Behavioural peer manager on the far side of the handover controller.
// Assumes the bench commands claim, presence, score and answer delay.
`timescale 1ns/100ps
module peer_model
  import failover_pkg::*;
(
  // Clocking
  input wire logic clk_sys,
  input wire logic reset_n,
  // From the controller
  input wire logic score_req,
  // Bench commands
  input wire logic claim,
  input wire logic absent,
  input wire logic [SCORE_W-1:0] score,
  input wire logic [3:0] lag,
  // Toward the controller
  output peer_status_t peer_o
);
  logic [3:0] wait_r;
  logic answer;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) wait_r <= 4'h0;
    else wait_r <= score_req ? wait_r + {3'h0, wait_r != 4'hf} : 4'h0;
  end
  assign answer = score_req && wait_r >= lag;
  always_comb begin
    peer_o = '0;
    peer_o.present_n = absent;
    peer_o.healthy_n = absent;
    // Claims only on command, while ours yields or to take over
    peer_o.negotiate = ~claim;
    peer_o.score_valid = answer;
    // Outside an answer the score shows inverted, never the stale value
    peer_o.score = answer ? score : ~score;
    peer_o.version = 8'h10;
  end
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the handover controller against a peer model.
// Assumes a shortened press count; stimulus moves on rising edges.
`timescale 1ns/100ps
module tb;
  import failover_pkg::*;
  localparam int unsigned PRESS = 20;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b1;
  logic absent = 1'b0;
  local_status_t own;
  peer_status_t peer;
  logic claim = 1'b0;
  logic [SCORE_W-1:0] pscore = 4'h0;
  logic [3:0] lag = 4'h5;
  logic health_out_n, role_negotiate_out, score_req, role_active;
  logic restart_go, manual_done, manual_refused;
  logic [SCORE_W-1:0] own_score;
  reason_t refuse_reason;
  log_entry_t log_out;
  reason_t log_rsn = RSN_NONE;
  int mismatches = 0;
  int checked = 0;
  int done_n = 0;
  int refused_n = 0;
  int restart_n = 0;

  always #12.5 clk_sys = ~clk_sys;

  failover_ctrl #(.PRESS_CYCLES(PRESS)) i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .ce(1'b1), .own_in(own), .peer_in(peer),
    .health_out_n(health_out_n), .role_negotiate_out(role_negotiate_out),
    .score_req(score_req), .own_score(own_score), .role_active(role_active),
    .restart_go(restart_go), .manual_done(manual_done), .manual_refused(manual_refused),
    .refuse_reason(refuse_reason), .log_out(log_out));
  peer_model i_peer (.clk_sys(clk_sys), .reset_n(reset_n), .score_req(score_req),
    .claim(claim), .absent(absent), .score(pscore), .lag(lag), .peer_o(peer));

  // Pulses are sampled away from the launching edge
  always @(negedge clk_sys) begin
    if (log_out.valid === 1'b1) log_rsn = log_out.reason;
    if (manual_done === 1'b1) done_n++;
    if (manual_refused === 1'b1) refused_n++;
    if (restart_go === 1'b1) restart_n++;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wait_role(input logic want);
    int i;
    i = 0;
    while (role_active !== want && i < 300) begin
      @(negedge clk_sys);
      i++;
    end
    chk("role_active", 8'(want), 8'(role_active));
    tick(1);
  endtask

  task automatic pulse_manual();
    own.manual_req <= 1'b1;
    tick(1);
    own.manual_req <= 1'b0;
  endtask

  task automatic regain();
    claim <= 1'b1;
    tick(8);
    claim <= 1'b0;
    wait_role(1'b1);
  endtask

  task automatic t_start();
    chk("health reset", 8'h01, 8'(health_out_n));
    chk("negotiate reset", 8'h01, 8'(role_negotiate_out));
    reset_n <= 1'b1;
    wait_role(1'b1);
    chk("claim", 8'h00, 8'(role_negotiate_out));
    claim <= 1'b1;
    wait_role(1'b0);
    claim <= 1'b0;
    wait_role(1'b1);
    $display("test start done");
  endtask

  task automatic t_block();
    for (int k = 0; k < 2; k++) begin
      if (k == 0) own.link_ok <= 1'b0;
      else own.sync_done <= 1'b0;
      tick(1);
      own.healthy_n <= 1'b1;
      tick(12);
      chk("blocked", 8'h01, 8'(role_active));
      chk("block reason", 8'(k + 1), 8'(log_rsn));
      own.link_ok <= 1'b1;
      own.sync_done <= 1'b1;
      wait_role(1'b0);
      chk("health yield", 8'h01, 8'(health_out_n));
      own.healthy_n <= 1'b0;
      regain();
    end
    $display("test block done");
  endtask

  task automatic t_force();
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: own.seated <= 1'b0;
        1: own.version <= 8'h0f;
        2: own.reset_btn <= 1'b1;
        default: own.reboot_req <= 1'b1;
      endcase
      tick(1);
      own.reboot_req <= 1'b0;
      if (k == 2) begin
        tick(PRESS);
        chk("short press", 8'h01, 8'(role_active));
      end
      wait_role(1'b0);
      own.seated <= 1'b1;
      own.version <= 8'h10;
      own.reset_btn <= 1'b0;
      regain();
    end
    chk("restart", 8'h01, 8'(restart_n));
    $display("test force done");
  endtask

  task automatic t_score();
    pscore <= 4'h1;
    own.trap_fail <= 1'b1;
    tick(40);
    chk("score one", 8'h01, 8'(own_score));
    chk("equal stays", 8'h01, 8'(role_active));
    chk("score reason", 8'(RSN_NOT_HEALTHIER), 8'(log_rsn));
    own.sensor_crit <= 1'b1;
    own.switch_present <= 1'b0;
    tick(8);
    chk("score three", 8'h03, 8'(own_score));
    own.trap_fail <= 1'b0;
    own.sensor_crit <= 1'b0;
    own.switch_present <= 1'b1;
    pscore <= 4'h0;
    tick(8);
    own.trap_fail <= 1'b1;
    wait_role(1'b0);
    own.trap_fail <= 1'b0;
    regain();
    $display("test score done");
  endtask

  task automatic t_manual();
    lag <= 4'h0;
    pulse_manual();
    wait_role(1'b0);
    chk("manual done", 8'h01, 8'(done_n));
    claim <= 1'b1;
    tick(8);
    pulse_manual();
    tick(6);
    chk("refused", 8'h01, 8'(refused_n));
    chk("refuse reason", 8'(RSN_NOT_ACTIVE), 8'(refuse_reason));
    claim <= 1'b0;
    wait_role(1'b1);
    $display("test manual done");
  endtask

  task automatic t_edge();
    absent <= 1'b1;
    tick(8);
    own.healthy_n <= 1'b1;
    tick(8);
    chk("alone stays", 8'h01, 8'(role_active));
    chk("alone reason", 8'(RSN_NO_STANDBY), 8'(log_rsn));
    own.healthy_n <= 1'b0;
    absent <= 1'b0;
    tick(8);
    own.eject_open <= 1'b1;
    wait_role(1'b0);
    chk("eject no done", 8'h01, 8'(done_n));
    own.eject_open <= 1'b0;
    regain();
    $display("test edge done");
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The whole sequence needs about four hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end

  initial begin
    // Reset falls after time zero so the asynchronous branch sees an edge
    #1 reset_n = 1'b0;
    own = '0;
    own.slot_primary = 1'b1;
    own.seated = 1'b1;
    own.link_ok = 1'b1;
    own.sync_done = 1'b1;
    own.switch_present = 1'b1;
    own.version = 8'h10;
    tick(20);
    t_start();
    t_block();
    t_force();
    t_score();
    t_manual();
    t_edge();
    close_out();
  end
endmodule
